/* fcad_pkg.sv */
// fcad_pkg: instruction codes, classes, states and reset values
package fcad_pkg;

  // wide (dedicated four-byte address) array reads
  localparam logic [7:0] OP_WIDE_NORMAL_READ = 8'h13;
  localparam logic [7:0] OP_WIDE_FAST_READ = 8'h0C;
  localparam logic [7:0] OP_WIDE_DOUBLE_RATE_FAST_READ = 8'h0E;
  localparam logic [7:0] OP_WIDE_DUAL_OUTPUT_READ = 8'h3C;
  localparam logic [7:0] OP_WIDE_QUAD_OUTPUT_READ = 8'h6C;
  localparam logic [7:0] OP_WIDE_DUAL_IO_READ = 8'hBC;
  localparam logic [7:0] OP_WIDE_QUAD_IO_READ = 8'hEC;
  localparam logic [7:0] OP_WIDE_DOUBLE_RATE_DUAL_IO_READ = 8'hBE;
  localparam logic [7:0] OP_WIDE_DOUBLE_RATE_QUAD_IO_READ = 8'hEE;
  // wide program and erase
  localparam logic [7:0] OP_WIDE_PAGE_PROGRAM = 8'h12;
  localparam logic [7:0] OP_WIDE_QUAD_PAGE_PROGRAM = 8'h34;
  localparam logic [7:0] OP_WIDE_BLOCK_CLEAR_256K = 8'hDC;
  // legacy reads, three or four address bytes
  localparam logic [7:0] OP_NORMAL_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_LEGACY_DOUBLE_RATE_FAST_READ = 8'h0D;
  localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_LEGACY_DOUBLE_RATE_DUAL_IO_READ = 8'hBD;
  localparam logic [7:0] OP_LEGACY_DOUBLE_RATE_QUAD_IO_READ = 8'hED;
  // legacy program and erase
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_BLOCK_CLEAR_256K = 8'hD8;
  // register access
  localparam logic [7:0] OP_BANK_REG_READ = 8'h16;
  localparam logic [7:0] OP_BANK_REG_WRITE = 8'h17;
  localparam logic [7:0] OP_BANK_REG_ACCESS_LEGACY = 8'hB9;
  localparam logic [7:0] OP_STATUS1_READ = 8'h05;
  localparam logic [7:0] OP_STATUS2_READ = 8'h07;
  localparam logic [7:0] OP_CONFIG1_READ = 8'h35;
  localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_FAIL_FLAG_CLEAR = 8'h30;
  localparam logic [7:0] OP_ERROR_CODE_STATUS_READ = 8'h18;
  localparam logic [7:0] OP_LEARNING_PATTERN_READ = 8'h41;
  localparam logic [7:0] OP_LEARNING_REG_NV_PROGRAM = 8'h43;
  localparam logic [7:0] OP_LEARNING_REG_VOLATILE_WRITE = 8'h4A;
  // identification
  localparam logic [7:0] OP_MAKER_SIGNATURE_READ = 8'h90;
  localparam logic [7:0] OP_IDENTITY_READ = 8'h9F;
  localparam logic [7:0] OP_ELECTRONIC_SIGNATURE_READ = 8'hAB;
  localparam logic [7:0] OP_DISCOVERABLE_PARAMS_READ = 8'h5A;

  // bank register layout and reset
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam int WIDE_BIT = 7;

  // command classes reported to the array side
  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_READ = 3'h1,
    CLS_PROG = 3'h2,
    CLS_ERASE = 3'h3,
    CLS_REG_RD = 3'h4,
    CLS_REG_WR = 3'h5,
    CLS_IDENT = 3'h6,
    CLS_CTRL = 3'h7
  } fcad_cls_t;

  // link frame states, gray along the path except the direct opcode-to-done step
  typedef enum logic [1:0] {
    ST_OPC = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h2,
    ST_DONE = 2'h3
  } fcad_st_t;

  // decoded instruction attributes
  typedef struct packed {
    fcad_cls_t cls;
    logic has_addr;
    logic dedic;
    logic legacy;
    logic data;
  } fcad_dec_t;

endpackage

/* fcad_decoder.sv */
// fcad_decoder: serial instruction decode and array address formation
// Contract
// - wide instructions always take 32-bit address
// - decode 13, 0C, 0E wide reads
// - decode 3C, 6C wide dual/quad output reads
// - decode BC, EC, BE, EE wide io reads
// - decode 12, 34, DC wide program/erase
// - decode 03, 0B, 0D legacy single reads
// - decode 3B, 6B, EB, BD, ED legacy reads
// - decode 02, 32, D8 legacy program/erase
// - wide enable is bank bit 7, reset 0
// - wide enable set: legacy takes four bytes
// - three-byte address is offset in bank
// - bank register supplies top address byte
// - bank bits volatile, reset to bank zero
// - reads stream across banks without delay
// - bank applies to start only, unchanged
// - bank bits 1:0 select banks 0-3; decoder uses bits 6:0, banks 0-127
// - decode 16, 17 and legacy bank access
// - decode 05, 07, 35, 01 register access
// - decode 06, 04, 30 latch and flags
// - decode 90, 9F, AB, 5A identification
// - decode 41, 43, 4A learning pattern
// - decode 18, always four address bytes
// - first byte is instruction, steers rest
// - address assembled most significant byte first
`timescale 1ns/100ps
module fcad_decoder
  import fcad_pkg::*;
#(
  parameter logic [31:0] ARRAY_LAST = 32'hFFFFFFFF
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_next_byte,
  output logic o_cmd_valid,
  output logic [2:0] o_cmd_class,
  output logic [7:0] o_opcode,
  output logic [31:0] o_addr,
  output logic o_addr_wide,
  output logic [7:0] o_bank,
  output logic o_wide_address_enable,
  output logic o_write_latch,
  output logic o_fail_clear
);

  // refuse an empty array
  if (ARRAY_LAST == 32'h0) begin : g_chk
    $error("fcad_decoder: ARRAY_LAST must be nonzero");
  end

  // instruction classifier shared by both clock domains
  function automatic fcad_dec_t dec(input logic [7:0] op);
    fcad_dec_t d;
    d.cls = CLS_NONE;
    d.has_addr = 1'b0;
    d.dedic = 1'b0;
    d.legacy = 1'b0;
    d.data = 1'b0;
    case (op)
      OP_WIDE_NORMAL_READ, OP_WIDE_FAST_READ,
      OP_WIDE_DOUBLE_RATE_FAST_READ,
      OP_WIDE_DUAL_OUTPUT_READ, OP_WIDE_QUAD_OUTPUT_READ,
      OP_WIDE_DUAL_IO_READ, OP_WIDE_QUAD_IO_READ,
      OP_WIDE_DOUBLE_RATE_DUAL_IO_READ,
      OP_WIDE_DOUBLE_RATE_QUAD_IO_READ: begin
        d.cls = CLS_READ;
        d.has_addr = 1'b1;
        d.dedic = 1'b1;
      end
      OP_WIDE_PAGE_PROGRAM, OP_WIDE_QUAD_PAGE_PROGRAM: begin
        d.cls = CLS_PROG;
        d.has_addr = 1'b1;
        d.dedic = 1'b1;
      end
      OP_WIDE_BLOCK_CLEAR_256K: begin
        d.cls = CLS_ERASE;
        d.has_addr = 1'b1;
        d.dedic = 1'b1;
      end
      OP_NORMAL_READ, OP_FAST_READ,
      OP_LEGACY_DOUBLE_RATE_FAST_READ,
      OP_DUAL_OUTPUT_READ, OP_QUAD_OUTPUT_READ, OP_DUAL_IO_READ,
      OP_QUAD_IO_READ, OP_LEGACY_DOUBLE_RATE_DUAL_IO_READ,
      OP_LEGACY_DOUBLE_RATE_QUAD_IO_READ: begin
        d.cls = CLS_READ;
        d.has_addr = 1'b1;
        d.legacy = 1'b1;
      end
      OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM: begin
        d.cls = CLS_PROG;
        d.has_addr = 1'b1;
        d.legacy = 1'b1;
      end
      OP_BLOCK_CLEAR_256K: begin
        d.cls = CLS_ERASE;
        d.has_addr = 1'b1;
        d.legacy = 1'b1;
      end
      OP_BANK_REG_READ: begin
        d.cls = CLS_REG_RD;
      end
      OP_BANK_REG_WRITE, OP_BANK_REG_ACCESS_LEGACY: begin
        d.cls = CLS_REG_WR;
        d.data = 1'b1;
      end
      OP_STATUS1_READ, OP_STATUS2_READ, OP_CONFIG1_READ: begin
        d.cls = CLS_REG_RD;
      end
      OP_STATUS_CONFIG_WRITE: begin
        d.cls = CLS_REG_WR;
      end
      OP_WRITE_LATCH_SET, OP_WRITE_LATCH_CLEAR,
      OP_FAIL_FLAG_CLEAR: begin
        d.cls = CLS_CTRL;
      end
      OP_MAKER_SIGNATURE_READ, OP_IDENTITY_READ,
      OP_ELECTRONIC_SIGNATURE_READ,
      OP_DISCOVERABLE_PARAMS_READ: begin
        d.cls = CLS_IDENT;
      end
      OP_LEARNING_PATTERN_READ: begin
        d.cls = CLS_REG_RD;
      end
      OP_LEARNING_REG_NV_PROGRAM,
      OP_LEARNING_REG_VOLATILE_WRITE: begin
        d.cls = CLS_REG_WR;
      end
      OP_ERROR_CODE_STATUS_READ: begin
        d.cls = CLS_REG_RD;
        d.has_addr = 1'b1;
        d.dedic = 1'b1;
      end
      default: begin
        d.cls = CLS_NONE;
      end
    endcase
    return d;
  endfunction

  // link side frame state, cleared whenever chip select is high
  typedef struct packed {
    fcad_st_t st;
    logic [2:0] bitc;
    logic [2:0] nbyte;
    logic [6:0] sh;
    logic [7:0] opc;
    logic wide;
    logic [31:0] addr;
    logic done;
  } fcad_link_t;

  // system side state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [7:0] bank;
    logic valid;
    logic [2:0] cls;
    logic [7:0] opc;
    logic [31:0] addr;
    logic wide;
    logic wlatch;
    logic fclr;
  } fcad_core_t;

  localparam fcad_core_t CORE_RST = '{bank: BANK_RST, default: '0};

  fcad_link_t l_q;
  fcad_link_t l_d;
  fcad_core_t c_q;
  fcad_core_t c_d;

  // word handed across, held on the link clock
  logic [7:0] h_opc_q;
  logic [31:0] h_addr_q;
  logic [7:0] h_data_q;
  logic h_wide_q;
  logic e1_q;
  logic e2_q;

  logic [7:0] bytev;
  logic byte_end;
  logic hold_ld;
  logic [7:0] hold_opc;
  fcad_dec_t odec;
  fcad_dec_t hdec;
  logic ev;

  // link frame decoder: instruction, address bytes, data byte
  always_comb begin
    l_d = l_q;
    bytev = {l_q.sh, i_si};
    byte_end = (l_q.bitc == 3'h7);
    odec = dec(bytev);
    l_d.sh = {l_q.sh[5:0], i_si};
    l_d.bitc = l_q.bitc + 3'h1;
    case (l_q.st)
      ST_OPC: begin
        if (byte_end) begin
          l_d.opc = bytev;
          l_d.nbyte = 3'h0;
          l_d.wide = odec.dedic | (odec.legacy & e2_q);
          if (odec.has_addr) begin
            l_d.st = ST_ADDR;
          end else if (odec.data) begin
            l_d.st = ST_DATA;
          end else begin
            l_d.st = ST_DONE;
            l_d.done = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        if (byte_end) begin
          l_d.addr = {l_q.addr[23:0], bytev};
          l_d.nbyte = l_q.nbyte + 3'h1;
          if (l_q.nbyte == (l_q.wide ? 3'h3 : 3'h2)) begin
            l_d.st = ST_DONE;
            l_d.done = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (byte_end) begin
          l_d.st = ST_DONE;
          l_d.done = 1'b1;
        end
      end
      ST_DONE: begin
        l_d.st = ST_DONE; // later bits are payload, not ours
      end
      default: begin
        l_d.st = ST_DONE;
      end
    endcase
    hold_ld = l_d.done & ~l_q.done;
    hold_opc = (l_q.st == ST_OPC) ? bytev : l_q.opc;
  end

  // frame registers, chip select high ends the frame
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // handed-over word and wide enable synchroniser
  always_ff @(posedge i_sck) begin
    e1_q <= c_q.bank[WIDE_BIT];
    e2_q <= e1_q;
    if (hold_ld) begin
      h_opc_q <= hold_opc;
      h_addr_q <= l_d.addr;
      h_data_q <= bytev;
      h_wide_q <= l_d.wide;
    end
  end

  // system side: take the word, form address, run registers
  always_comb begin
    c_d = c_q;
    c_d.s1 = l_q.done;
    c_d.s2 = c_q.s1;
    c_d.s3 = c_q.s2;
    c_d.valid = 1'b0;
    c_d.fclr = 1'b0;
    ev = c_q.s2 & ~c_q.s3;
    hdec = dec(h_opc_q);
    if (ev) begin
      if (hdec.cls != CLS_NONE) begin
        c_d.valid = 1'b1;
        c_d.cls = hdec.cls;
        c_d.opc = h_opc_q;
        c_d.wide = h_wide_q;
        if (hdec.has_addr) begin
          if (h_wide_q) begin
            c_d.addr = h_addr_q;
          end else begin
            // bank bits 6:0 on top of the offset, bit 31 forced to zero
            c_d.addr = {1'b0, c_q.bank[6:0], h_addr_q[23:0]};
          end
        end
        if (hdec.cls == CLS_REG_WR && hdec.data) begin
          c_d.bank = h_data_q;
        end
        if (h_opc_q == OP_WRITE_LATCH_SET) begin
          c_d.wlatch = 1'b1;
        end
        if (h_opc_q == OP_WRITE_LATCH_CLEAR) begin
          c_d.wlatch = 1'b0;
        end
        if (h_opc_q == OP_FAIL_FLAG_CLEAR) begin
          c_d.fclr = 1'b1;
        end
      end
    end else if (i_next_byte && c_q.addr != ARRAY_LAST) begin
      // plain increment, bank register left alone
      c_d.addr = c_q.addr + 32'h1;
    end
  end

  // system registers, bank returns to zero at reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // outputs straight from flops
  assign o_cmd_valid = c_q.valid;
  assign o_cmd_class = c_q.cls;
  assign o_opcode = c_q.opc;
  assign o_addr = c_q.addr;
  assign o_addr_wide = c_q.wide;
  assign o_bank = c_q.bank;
  assign o_wide_address_enable = c_q.bank[WIDE_BIT];
  assign o_write_latch = c_q.wlatch;
  assign o_fail_clear = c_q.fclr;

  // checks on the system side
  a_bank_reset: assert property (
    @(posedge i_clk) !i_nrst |=> (o_bank == BANK_RST)
      && !o_wide_address_enable && !o_cmd_valid)
    else $error("bank not cleared by reset");

  a_bank_write: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    ev && (h_opc_q == OP_BANK_REG_WRITE) |=> o_bank == $past(h_data_q))
    else $error("bank write lost");

  a_narrow_top: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    ev && hdec.has_addr && !h_wide_q
      |=> o_addr == {1'b0, o_bank[6:0], $past(h_addr_q[23:0])})
    else $error("narrow address not banked");

  a_wide_full: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    ev && hdec.has_addr && h_wide_q |=> o_addr == $past(h_addr_q)
      && o_addr_wide)
    else $error("wide address not taken whole");

  a_dedic_wide: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    ev && hdec.dedic |=> o_cmd_valid && o_addr_wide)
    else $error("dedicated command not wide");

  a_ignore_unknown: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    ev && hdec.cls == CLS_NONE
      |=> !o_cmd_valid && $stable(o_bank) && $stable(o_write_latch))
    else $error("unknown instruction acted on");

  a_stream_step: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !ev && i_next_byte && o_addr != ARRAY_LAST
      |=> o_addr == $past(o_addr) + 32'h1)
    else $error("stream address did not step");

  a_stream_bank: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !ev |=> $stable(o_bank))
    else $error("bank changed without write");

  a_valid_pulse: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    o_cmd_valid |=> !o_cmd_valid ##1 !o_cmd_valid)
    else $error("valid longer than one cycle");

  a_latch_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    o_cmd_valid && o_opcode == OP_WRITE_LATCH_SET |-> o_write_latch)
    else $error("write latch not set");

  // main scenarios
  c_narrow_read: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_cmd_valid && o_cmd_class == CLS_READ && !o_addr_wide);
  c_wide_read: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_cmd_valid && o_cmd_class == CLS_READ && o_addr_wide);
  c_bank_write: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_cmd_valid && o_cmd_class == CLS_REG_WR && o_bank != BANK_RST);
  c_bank_cross: cover property (@(posedge i_clk) disable iff (!i_nrst)
    i_next_byte && o_addr[23:0] == 24'hFFFFFF);

endmodule

/* fcad_host_model.sv */
// fcad_host_model: serial host driving chip select, link clock and data
`timescale 1ns/100ps
module fcad_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  // link idle: clock parked low; a clockless select pulse clears frame logic
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_si = 1'b0;
    #1 o_cs_n = 1'b1;
  end

  // one frame: instruction byte, then nb bytes of val, msb first
  task automatic send(input logic [7:0] op, input logic [31:0] val,
                      input int nb);
    logic [39:0] sh;
    int nbits;
    sh = {op, val << (8 * (4 - nb))};
    nbits = 8 + 8 * nb;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_si = sh[39 - i];
      #62.5 o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    // keep select low past the last edge, then release
    #62.5 o_cs_n = 1'b1;
    o_si = ~o_si;  // released line shows no stale value
    #250;
  endtask
endmodule

/* flash_command_address_decode_test.sv */
// flash_command_address_decode_test: self-checking bench for the decoder
`timescale 1ns/100ps
module flash_command_address_decode_test;
  import fcad_pkg::*;
  logic i_clk, i_nrst, i_next_byte, sck, cs_n, si;
  logic o_cmd_valid, o_addr_wide, o_wide_address_enable;
  logic o_write_latch, o_fail_clear;
  logic [2:0] o_cmd_class;
  logic [7:0] o_opcode, o_bank, exp_bank, op;
  logic [31:0] o_addr;
  logic [3:0] cl, nb;
  logic exp_latch;
  int bad_count, compares, vcount, fcount;
  // rows: opcode, class (F = not checked), address or data bytes
  logic [15:0] rows [42] = '{
    16'h1751, 16'h1314, 16'h0C14, 16'h0E14, 16'h3C14, 16'h6C14, 16'hBC14,
    16'hEC14, 16'hBE14, 16'hEE14, 16'h1224, 16'h3424, 16'hDC34,
    16'h0313, 16'h0B13, 16'h0D13, 16'h3B13, 16'h6B13, 16'hBB13,
    16'hEB13, 16'hBD13, 16'hED13, 16'h0223, 16'h3223, 16'hD833,
    16'hB951, 16'h1640, 16'h0540, 16'h0740, 16'h3540, 16'h0150,
    16'h0670, 16'h0470, 16'h3070, 16'h9060, 16'h9F60, 16'hAB60,
    16'h5A60, 16'h4140, 16'h4350, 16'h4A50, 16'h1844};

  fcad_decoder dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_next_byte(i_next_byte), .o_cmd_valid(o_cmd_valid),
    .o_cmd_class(o_cmd_class), .o_opcode(o_opcode), .o_addr(o_addr),
    .o_addr_wide(o_addr_wide), .o_bank(o_bank),
    .o_wide_address_enable(o_wide_address_enable),
    .o_write_latch(o_write_latch), .o_fail_clear(o_fail_clear)
  );
  fcad_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));

  // system clock
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  // count one-cycle pulses
  always @(posedge i_clk) begin
    if (o_cmd_valid === 1'b1) vcount++;
    if (o_fail_clear === 1'b1) fcount++;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // send one frame and count the command pulses it gives
  task automatic frame(input logic [7:0] o, input logic [31:0] v,
                       input int n, input int pulses);
    int v0;
    v0 = vcount;
    host.send(o, v, n);
    repeat (8) @(negedge i_clk);
    chk_val(32'(vcount - v0), 32'(pulses));
  endtask

  // hold the advance request for n cycles
  task automatic advance(input int n);
    i_next_byte = 1'b1;
    repeat (n) @(negedge i_clk);
    i_next_byte = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog about 2.7 times the expected run length
  initial begin
    #500000;
    bad_count++;
    results();
  end

  initial begin
    i_nrst = 1'b0;
    i_next_byte = 1'b0;
    exp_bank = 8'h00;
    exp_latch = 1'b0;
    repeat (16) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_val(32'(o_bank), 32'h0);
    chk_flag(o_wide_address_enable, 1'b0);
    $display("test reset done");
    // every known instruction, one frame each
    foreach (rows[k]) begin
      op = rows[k][15:8];
      cl = rows[k][7:4];
      nb = rows[k][3:0];
      frame(op, (nb == 4'h1) ? 32'h02 : 32'hA1B2C3D4, int'(nb), 1);
      if (cl != 4'hF) chk_val(32'(o_cmd_class), 32'(cl));
      chk_val(32'(o_opcode), 32'(op));
      if (nb == 4'h4) chk_val(o_addr, 32'hA1B2C3D4);
      if (nb == 4'h4) chk_flag(o_addr_wide, 1'b1);
      if (nb == 4'h3) chk_val(o_addr, {exp_bank, 24'hB2C3D4});
      if (nb == 4'h3) chk_flag(o_addr_wide, 1'b0);
      if (nb == 4'h1) exp_bank = 8'h02;
      chk_val(32'(o_bank), 32'(exp_bank));
      if (op == 8'h06) exp_latch = 1'b1;
      if (op == 8'h04) exp_latch = 1'b0;
      chk_flag(o_write_latch, exp_latch);
    end
    chk_val(32'(fcount), 32'h1);
    $display("test table done");
    // unknown codes and a frame cut short do nothing
    frame(8'hFF, 32'h0, 0, 0);
    frame(8'h38, 32'h0, 0, 0);
    frame(8'h03, 32'h0, 2, 0);
    chk_val(32'(o_bank), 32'h02);
    $display("test ignore done");
    // wide enable makes legacy commands take four bytes
    frame(8'h17, 32'h83, 1, 1);
    chk_flag(o_wide_address_enable, 1'b1);
    frame(8'h03, 32'h05060708, 4, 1);
    chk_val(o_addr, 32'h05060708);
    chk_flag(o_addr_wide, 1'b1);
    frame(8'h13, 32'h0A0B0C0D, 4, 1);
    chk_val(o_addr, 32'h0A0B0C0D);
    frame(8'hB9, 32'h03, 1, 1);
    chk_flag(o_wide_address_enable, 1'b0);
    frame(8'h0B, 32'h00123456, 3, 1);
    chk_val(o_addr, 32'h03123456);
    $display("test wide done");
    // streaming across a bank edge and at the array end
    frame(8'h03, 32'h00FFFFFF, 3, 1);
    advance(2);
    chk_val(o_addr, 32'h04000001);
    chk_val(32'(o_bank), 32'h03);
    frame(8'h13, 32'hFFFFFFFE, 4, 1);
    advance(3);
    chk_val(o_addr, 32'hFFFFFFFF);
    $display("test stream done");
    // second reset in mid-run clears bank and latch
    frame(8'h06, 32'h0, 0, 1);
    chk_flag(o_write_latch, 1'b1);
    i_nrst = 1'b0;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_val(32'(o_bank), 32'h0);
    chk_flag(o_write_latch, 1'b0);
    $display("test reset again done");
    results();
  end
endmodule
